// ==== core/processor_mode_status_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module processor_mode_status_reg #(
  parameter bit HAS_SATURATE = 1'b1 // Variant supports saturation bits
) (
  input wire logic clk, // Core clock 25 MHz
  input wire logic reset_n, // Hardware reset, sync active low
  input wire logic softReset, // Software reset instruction pulse
  input wire logic romDisablePin, // Mode pin, asynchronous
  input wire logic storeValid, // Mapped-register store strobe
  input wire logic [6:0] storeIndex, // Mapped-register index
  input wire logic [15:0] storeData, // Store data
  input wire logic [15:0] progAddr, // Internal program address
  input wire logic [15:0] dataAddr, // Data address under decode
  input wire logic extValid, // External bus access active
  input wire logic [15:0] extAddr, // External bus address
  output logic [15:0] processor_mode_reg, // Register readback
  output logic [8:0] vector_page_pointer, // Vector page
  output logic [15:0] vectorBase, // Vector page base address
  output logic rom_disable_mode, // On-chip ROM off
  output logic romProgEnable, // ROM in program space
  output logic ram_overlay, // Overlay bit
  output logic ramProgHit, // Data address may be overlaid
  output logic address_visibility, // Visibility bit
  output logic data_rom_map, // ROM in data space
  output logic clock_output_off, // Clock output disabled
  output logic clockOut, // Clock output pin
  output logic multiply_saturate, // Multiply saturate bit
  output logic store_saturate, // Store saturate bit
  output logic [15:0] addrPins // External address pins
);
  import pmode_pkg::*;

  logic pinSync;
  logic [8:0] ptr_q, ptr_d;
  logic [6:0] low_q, low_d;
  logic rstSeen_q, rstSeen_d;
  logic [1:0] div_q, div_d;
  logic clk_q, clk_d;
  logic romEn_q, romEn_d;
  logic ovHit_q, ovHit_d;
  logic [15:0] addrPinsW;
  logic wrHit;

  mode_pin_sync u_sync (
    .clk(clk),
    .pinIn(romDisablePin),
    .pinSync(pinSync)
  );

  assign wrHit = storeValid && (storeIndex == PMODE_INDEX);

  // Register fields; software reset spares the pointer and ROM bit
  always_comb begin
    ptr_d = ptr_q;
    low_d = low_q;
    rstSeen_d = 1'b1;
    if (!rstSeen_q) begin
      // First cycle after release: catch the synchronised pin
      low_d[ROMDIS_BIT] = pinSync;
    end
    if (softReset) begin
      low_d[RAM_OVERLAY_BIT] = 1'b0;
      low_d[ADDRESS_VISIBILITY_BIT] = 1'b0;
      low_d[DATA_ROM_MAP_BIT] = 1'b0;
      low_d[CLOCK_OUTPUT_OFF_BIT] = 1'b0;
      low_d[MULTIPLY_SATURATE_BIT] = 1'b0;
      low_d[SST_BIT] = 1'b0;
    end else if (wrHit) begin
      ptr_d = storeData[REG_W-1:PTR_LSB];
      low_d = storeData[6:0];
      if (!HAS_SATURATE) begin
        low_d[MULTIPLY_SATURATE_BIT] = 1'b0;
        low_d[SST_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_q <= PTR_RESET;
      low_q <= LOW_RESET;
      rstSeen_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      low_q <= low_d;
      rstSeen_q <= rstSeen_d;
    end
  end

  // Clock output; held high while disabled so the pin never glitches low
  always_comb begin
    div_d = div_q + 2'h1;
    clk_d = clk_q;
    if (low_q[CLOCK_OUTPUT_OFF_BIT]) begin
      div_d = 2'h0;
      clk_d = 1'b1;
    end else if (div_q == CLKDIV_HALF) begin
      div_d = 2'h0;
      clk_d = ~clk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_q <= 2'h0;
      clk_q <= 1'b1;
    end else begin
      div_q <= div_d;
      clk_q <= clk_d;
    end
  end

  // Registered map decodes keep every output straight from a flop
  always_comb begin
    romEn_d = ~low_d[ROMDIS_BIT];
    ovHit_d = low_d[RAM_OVERLAY_BIT] && (dataAddr > PAGE0_LAST);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      romEn_q <= 1'b1;
      ovHit_q <= 1'b0;
    end else begin
      romEn_q <= romEn_d;
      ovHit_q <= ovHit_d;
    end
  end

  address_visibility_out u_address_visibility (
    .clk(clk),
    .reset_n(reset_n),
    .visible(low_q[ADDRESS_VISIBILITY_BIT]),
    .extValid(extValid),
    .extAddr(extAddr),
    .progAddr(progAddr),
    .pinAddr(addrPinsW)
  );

  assign processor_mode_reg = {ptr_q, low_q};
  assign vector_page_pointer = ptr_q;
  assign vectorBase = {ptr_q, 7'h00};
  assign rom_disable_mode = low_q[ROMDIS_BIT];
  assign romProgEnable = romEn_q;
  assign ram_overlay = low_q[RAM_OVERLAY_BIT];
  assign ramProgHit = ovHit_q;
  assign address_visibility = low_q[ADDRESS_VISIBILITY_BIT];
  assign data_rom_map = low_q[DATA_ROM_MAP_BIT];
  assign clock_output_off = low_q[CLOCK_OUTPUT_OFF_BIT];
  assign clockOut = clk_q;
  assign multiply_saturate = low_q[MULTIPLY_SATURATE_BIT];
  assign store_saturate = low_q[SST_BIT];
  assign addrPins = addrPinsW;
endmodule
`default_nettype wire

// ==== common/pmode_pkg.sv ====
// Notes on behaviour
// - Bits 15..7 hold the 9-bit vector page.
// - Hardware reset sets vector page to all ones.
// - Software reset leaves vector page unchanged.
// - Register written by mapped-register store instructions.
// - ROM-disable bit 6 low maps on-chip ROM.
// - ROM-disable bit loads from mode pin in the first cycle after hardware reset.
// - Overlay bit 5 puts RAM in program space.
// - Data page zero never overlays into program space.
// - Visibility low: external address holds last value.
// - Saturation bits exist only on supporting variants.
// - Visibility high: internal program address on pins.
// - Data ROM bit 3 maps ROM into data.
// - Clock-off bit 2 holds clock output high.
package pmode_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 16;
  localparam int PTR_LSB = 7;
  localparam int PTR_W = 9;
  localparam int ROMDIS_BIT = 6;
  localparam int RAM_OVERLAY_BIT = 5;
  localparam int ADDRESS_VISIBILITY_BIT = 4;
  localparam int DATA_ROM_MAP_BIT = 3;
  localparam int CLOCK_OUTPUT_OFF_BIT = 2;
  localparam int MULTIPLY_SATURATE_BIT = 1;
  localparam int SST_BIT = 0;
  localparam logic [8:0] PTR_RESET = 9'h1FF;
  localparam logic [6:0] LOW_RESET = 7'h00;
  // Index of the register among the memory-mapped registers (arbitrary)
  localparam logic [6:0] PMODE_INDEX = 7'h1D;
  // Data page zero spans the lowest addresses
  localparam logic [ADDR_W-1:0] PAGE0_LAST = 16'h007F;
  // Clock output divider last count; the half period is this plus one core cycles
  localparam logic [1:0] CLKDIV_HALF = 2'h1;
endpackage

// ==== core/mode_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module mode_pin_sync (
  input wire logic clk, // Core clock
  input wire logic pinIn, // Asynchronous pin
  output logic pinSync // Synchronised level
);
  logic meta_q;
  logic sync_q;
  // Two flops before anyone looks at the pin
  always_ff @(posedge clk) begin
    meta_q <= pinIn;
    sync_q <= meta_q;
  end
  assign pinSync = sync_q;
endmodule
`default_nettype wire

// ==== core/address_visibility_out.sv ====
`timescale 1ns/1ps
`default_nettype none
module address_visibility_out (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Sync reset
  input wire logic visible, // Visibility enabled
  input wire logic extValid, // External access active
  input wire logic [15:0] extAddr, // External access address
  input wire logic [15:0] progAddr, // Internal program address
  output logic [15:0] pinAddr // Address pins
);
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  // External cycles always drive; internal ones only when visible
  always_comb begin
    addr_d = addr_q;
    if (extValid) begin
      addr_d = extAddr;
    end else if (visible) begin
      addr_d = progAddr;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_q <= 16'h0000;
    end else begin
      addr_q <= addr_d;
    end
  end
  assign pinAddr = addr_q;
endmodule
`default_nettype wire

// ==== test/pmode_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmode_sva (
  input wire logic clk, reset_n, softReset, storeValid, extValid,
  input wire logic [6:0] storeIndex,
  input wire logic [15:0] storeData, progAddr, dataAddr,
  input wire logic [15:0] processor_mode_reg, vectorBase, addrPins,
  input wire logic ramProgHit, address_visibility,
  input wire logic clock_output_off, clockOut
);
  import pmode_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Soft reset wins over a store in the same cycle
  sequence s_take;
    storeValid && storeIndex == PMODE_INDEX && !softReset;
  endsequence
  sequence s_other;
    storeValid && storeIndex != PMODE_INDEX && !softReset;
  endsequence
  property p_store;
    s_take |=> processor_mode_reg == $past(storeData);
  endproperty
  property p_refuse;
    s_other |=> $stable(processor_mode_reg);
  endproperty
  property p_soft;
    softReset |=> processor_mode_reg[5:0] == 6'h00 && $stable(processor_mode_reg[15:6]);
  endproperty
  // Checked through reset, so the disable is switched off here
  property p_hard;
    disable iff (1'b0) !reset_n |=> processor_mode_reg == 16'hFF80;
  endproperty
  property p_base;
    vectorBase == {processor_mode_reg[15:7], 7'h00};
  endproperty
  property p_clock_output_off;
    clock_output_off [*2] |-> clockOut;
  endproperty
  property p_hold;
    !address_visibility && !extValid |=> $stable(addrPins);
  endproperty
  property p_show;
    address_visibility && !extValid |=> addrPins == $past(progAddr);
  endproperty
  property p_page0;
    $past(dataAddr) <= PAGE0_LAST |-> !ramProgHit;
  endproperty
  a_store: assert property (p_store) else $error("store lost");
  a_refuse: assert property (p_refuse) else $error("foreign store");
  a_soft: assert property (p_soft) else $error("soft reset");
  a_hard: assert property (p_hard) else $error("hard reset");
  a_base: assert property (p_base) else $error("vector base");
  a_clock_output_off: assert property (p_clock_output_off) else $error("clock runs");
  a_hold: assert property (p_hold) else $error("pins moved");
  a_show: assert property (p_show) else $error("pins hidden");
  a_page0: assert property (p_page0) else $error("page zero hit");
endmodule
`default_nettype wire

// ==== test/processor_mode_status_reg_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
bind processor_mode_status_reg pmode_sva i_sva (.*);
module processor_mode_status_reg_bench;
  import pmode_pkg::*;
  logic clk, reset_n, softReset, romDisablePin, storeValid, extValid;
  logic [6:0] storeIndex;
  logic [15:0] storeData, progAddr, dataAddr, extAddr, m, ea;
  logic [15:0] processor_mode_reg, vectorBase, addrPins;
  logic [8:0] vector_page_pointer;
  logic rom_disable_mode, romProgEnable, ram_overlay, ramProgHit;
  logic address_visibility, data_rom_map, clock_output_off, clockOut;
  logic multiply_saturate, store_saturate;
  logic ck;
  logic [1:0] dv;
  logic [31:0] seed = 32'h8566;
  int err_total, compares;
  processor_mode_status_reg i_dut (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hold hardware reset while the pin sync settles, then release it and check the pin capture
  task automatic hard_reset(input logic pin, input logic [15:0] e);
    reset_n = 0;
    romDisablePin = pin;
    repeat (3) @(negedge clk);
    chk(processor_mode_reg, 16'hFF80);
    reset_n = 1;
    repeat (2) @(negedge clk);
    romDisablePin = ~pin; // Late pin moves must be ignored
    chk(processor_mode_reg, e);
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    {softReset, storeValid, extValid, storeIndex} = '0;
    {storeData, progAddr, dataAddr, extAddr} = '0;
    hard_reset(1'b1, 16'hFFC0);
    m = 16'hFFC0;
    ea = 16'h0000;
    // Clock output has toggled low once by the end of the reset checks
    ck = 1'b0;
    dv = 2'h0;
    // Random traffic; the first stores turn on clock-off and visibility
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      storeValid = seed[0] | (i < 2);
      storeIndex = (seed[1] | (i < 2)) ? PMODE_INDEX : seed[8:2];
      storeData = (i < 2) ? 16'h0014 : seed[31:16];
      softReset = (seed[11:9] == 3'h0) && i > 8;
      extValid = seed[12];
      progAddr = seed[31:16];
      extAddr = ~seed[31:16];
      dataAddr = {seed[13] ? 9'h000 : seed[24:16], seed[6:0]};
      ea = extValid ? extAddr : (m[4] ? progAddr : ea);
      // Divide-by-four clock, parked high while clock-off is set
      if (m[2]) begin
        dv = 2'h0;
        ck = 1'b1;
      end else if (dv == 2'h1) begin
        dv = 2'h0;
        ck = ~ck;
      end else begin
        dv = dv + 2'h1;
      end
      if (softReset) m[5:0] = 6'h00;
      else if (storeValid && storeIndex == PMODE_INDEX) m = storeData;
      @(negedge clk);
      chk({15'h0, clockOut}, {15'h0, ck});
      chk(processor_mode_reg, m);
      chk({vector_page_pointer, rom_disable_mode, ram_overlay,
           address_visibility, data_rom_map, clock_output_off,
           multiply_saturate, store_saturate}, m);
      chk(vectorBase, {m[15:7], 7'h00});
      chk(addrPins, ea);
      chk({14'h0, m[5] && dataAddr > PAGE0_LAST, ~m[6]},
          {14'h0, ramProgHit, romProgEnable});
    end
    {softReset, storeValid} = '0;
    hard_reset(1'b0, 16'hFF80);
    tally_and_finish();
  end
endmodule
`default_nettype wire
